// file: inc/adcc_consts.svh
/*
  Constants for the converter calibration and clock control pair: register
  offsets, field positions, reset values and timing counts.
  Assumes a 125 MHz sys_clk that is also the converter sample clock.
*/
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// Clock rate
`define ADCC_CLK_MHZ 125
// Conversion pipeline depth in sample clocks
`define ADCC_LATENCY 10
// Calibration figures in ms; nominal and worst case
`define ADCC_CAL_NOM_MS 560
`define ADCC_CAL_MAX_MS 1000
`define ADCC_CAL_CYC (`ADCC_CAL_NOM_MS * 1000 * `ADCC_CLK_MHZ)
`define ADCC_CAL_MAX_CYC (`ADCC_CAL_MAX_MS * 1000 * `ADCC_CLK_MHZ)
// Loop relock time in us
`define ADCC_LOCK_US 100
`define ADCC_LOCK_CYC (`ADCC_LOCK_US * `ADCC_CLK_MHZ)
// Internal power-on hold of the reset pin, in cycles
`define ADCC_POR_CYC 16
// Host recalibration low pulse, in cycles (one is the least)
`define ADCC_RECAL_CYC 2
// Register offsets
`define ADCC_CAL_STATE_ADDR 8'hb6
`define ADCC_DIV_CTRL_ADDR 8'h74
`define ADCC_DLL_CTRL_ADDR 8'h75
// Field positions
`define ADCC_CAL_DONE_BIT 0
`define ADCC_LOCKED_BIT 1
`define ADCC_DIV_OVR_BIT 2
`define ADCC_DLL_SLOW_BIT 0
// Reset values and patterns
`define ADCC_DIV_CTRL_RST 8'h00
`define ADCC_DLL_CTRL_RST 8'h00
`define ADCC_CAL_PATTERN 16'hcccc

`endif

// file: inc/adcc_pkg.sv
/*
  Types shared by both ends of the converter control link.
  Assumes adcc_consts.svh supplies the numeric constants.
*/
package adcc_pkg;
  // Level seen on the divider select pin
  typedef enum logic [1:0] {
    ADCC_PIN_GND,
    ADCC_PIN_FLOAT,
    ADCC_PIN_SUPPLY
  } adcc_pin_e;

  // Device sequencing states
  typedef enum logic [1:0] {
    ADCC_ST_POR,
    ADCC_ST_HOLD,
    ADCC_ST_CAL,
    ADCC_ST_RUN
  } adcc_state_e;

  typedef logic [7:0] adcc_byte_t;
  typedef logic [15:0] adcc_word_t;
endpackage : adcc_pkg

// file: inc/adcc_if.sv
/*
  Link between the converter device end and the host end.
  Assumes both ends run on the same sys_clk; resolves the open-drain reset pin.
*/
`timescale 1ns/1ps
interface adcc_if;
  import adcc_pkg::*;
  // Open-drain active-low reset pin, pulled up when nobody drives
  logic dev_reset_low_o;
  logic dev_reset_low_oe;
  logic host_reset_low_o;
  logic host_reset_low_oe;
  logic reset_low_pin;
  // Divider select strap, driven by host board logic
  adcc_pin_e divider_select_pin;
  // Configuration port
  logic cfg_wr;
  logic cfg_rd;
  adcc_byte_t cfg_addr;
  adcc_byte_t cfg_wdata;
  adcc_byte_t cfg_rdata;
  logic cfg_rvalid;
  // Serial data output line, pulled up by the device only
  logic sdo_o;
  logic sdo_oe;
  // Output data and output clock
  adcc_word_t data_out;
  logic output_clock_pair;

  assign reset_low_pin = !((dev_reset_low_oe && !dev_reset_low_o) ||
                           (host_reset_low_oe && !host_reset_low_o));

  modport dev (
    output dev_reset_low_o, dev_reset_low_oe, cfg_rdata, cfg_rvalid,
    output sdo_o, sdo_oe, data_out, output_clock_pair,
    input reset_low_pin, divider_select_pin, cfg_wr, cfg_rd, cfg_addr, cfg_wdata
  );
  modport host (
    output host_reset_low_o, host_reset_low_oe, divider_select_pin,
    output cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    input reset_low_pin, cfg_rdata, cfg_rvalid, sdo_o, sdo_oe,
    input data_out, output_clock_pair
  );
endinterface : adcc_if

// file: rtl/adcc_dev.sv
/*
  Device end: calibration sequencing, output clock divider, loop lock
  tracking and the configuration registers of the converter.
  Assumes sys_clk is the sample clock and rst_n stands for supply power-on.
*/
`include "adcc_consts.svh"
`timescale 1ns/1ps
module adcc_dev #(
  parameter int unsigned CAL_CYCLES = `ADCC_CAL_CYC,
  parameter int unsigned LOCK_CYCLES = `ADCC_LOCK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  adcc_if.dev link,
  input wire logic [13:0] conv_in,
  output logic cal_done,
  output logic dll_locked,
  output logic dll_slow
);
  import adcc_pkg::*;

  adcc_state_e state_ff;
  adcc_state_e nxt_state;
  logic [31:0] cnt_ff;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_prev_ff;
  adcc_pin_e pin_meta_ff;
  adcc_pin_e pin_sync_ff;
  adcc_byte_t div_ctrl_ff;
  adcc_byte_t dll_ctrl_ff;
  logic cal_done_ff;
  logic sdo_oe_ff;
  logic [2:0] ratio;
  logic [2:0] ratio_prev_ff;
  logic [1:0] div_cnt_ff;
  logic oclk_ff;
  logic [31:0] lock_cnt_ff;
  logic locked_ff;
  adcc_word_t pipe_ff [`ADCC_LATENCY-1];
  adcc_word_t data_ff;
  adcc_byte_t rdata_ff;
  logic rvalid_ff;
  logic por_drive_ff;
  logic rise;

  // Two flops on the reset pin and the divider select pin before any logic reads them
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
      pin_meta_ff <= ADCC_PIN_FLOAT;
      pin_sync_ff <= ADCC_PIN_FLOAT;
    end else begin
      rst_meta_ff <= link.reset_low_pin;
      rst_sync_ff <= rst_meta_ff;
      rst_prev_ff <= rst_sync_ff;
      pin_meta_ff <= link.divider_select_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign rise = rst_sync_ff && !rst_prev_ff;

  // Sequencer; a low reset pin in calibration or run aborts back to hold
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADCC_ST_POR: begin
        if (cnt_ff == 32'(`ADCC_POR_CYC - 1)) begin
          nxt_state = ADCC_ST_HOLD;
        end
      end
      ADCC_ST_HOLD: begin
        if (rise) begin
          nxt_state = ADCC_ST_CAL;
        end
      end
      ADCC_ST_CAL: begin
        if (!rst_sync_ff) begin
          nxt_state = ADCC_ST_HOLD;
        end else if (cnt_ff == CAL_CYCLES - 1) begin
          nxt_state = ADCC_ST_RUN;
        end
      end
      ADCC_ST_RUN: begin
        if (!rst_sync_ff) begin
          nxt_state = ADCC_ST_HOLD;
        end
      end
      default: nxt_state = ADCC_ST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ADCC_ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Shared counter: power-on hold, then calibration length
  always_ff @(posedge sys_clk) begin
    if (!rst_n || nxt_state != state_ff) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  // Internal power-on pull-down of the reset pin, released afterwards
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      por_drive_ff <= 1'b1;
    end else if (state_ff == ADCC_ST_POR && nxt_state != ADCC_ST_POR) begin
      por_drive_ff <= 1'b0;
    end
  end

  // Done flag drops as soon as reset is seen, rises at calibration end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rst_sync_ff) begin
      cal_done_ff <= 1'b0;
      sdo_oe_ff <= 1'b1;
    end else if (state_ff == ADCC_ST_CAL && nxt_state == ADCC_ST_RUN) begin
      cal_done_ff <= 1'b1;
      sdo_oe_ff <= 1'b0;
    end
  end

  // Configuration writes; the host keeps quiet during calibration
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_ctrl_ff <= `ADCC_DIV_CTRL_RST;
      dll_ctrl_ff <= `ADCC_DLL_CTRL_RST;
    end else if (link.cfg_wr) begin
      if (link.cfg_addr == `ADCC_DIV_CTRL_ADDR) begin
        div_ctrl_ff <= link.cfg_wdata & 8'h07;
      end
      if (link.cfg_addr == `ADCC_DLL_CTRL_ADDR) begin
        dll_ctrl_ff <= link.cfg_wdata & 8'h01;
      end
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= link.cfg_rd;
      rdata_ff <= 8'h00;
      if (link.cfg_rd) begin
        case (link.cfg_addr)
          `ADCC_CAL_STATE_ADDR: rdata_ff <= {6'h00, locked_ff, cal_done_ff};
          `ADCC_DIV_CTRL_ADDR: rdata_ff <= div_ctrl_ff;
          `ADCC_DLL_CTRL_ADDR: rdata_ff <= dll_ctrl_ff;
          default: rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // Ratio from override field when enabled, else from the strap
  always_comb begin
    if (div_ctrl_ff[`ADCC_DIV_OVR_BIT]) begin
      case (div_ctrl_ff[1:0])
        2'h0: ratio = 3'h1;
        2'h1: ratio = 3'h2;
        default: ratio = 3'h4;
      endcase
    end else begin
      case (pin_sync_ff)
        ADCC_PIN_GND: ratio = 3'h2;
        ADCC_PIN_SUPPLY: ratio = 3'h4;
        default: ratio = 3'h1;
      endcase
    end
  end

  // Output clock: half period equals ratio cycles, held low in reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rst_sync_ff) begin
      oclk_ff <= 1'b0;
      div_cnt_ff <= 2'h0;
    end else if (div_cnt_ff == 2'(ratio - 3'h1)) begin
      oclk_ff <= !oclk_ff;
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // Relock after any ratio change; a count in cycles scales with the clock rate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ratio_prev_ff <= 3'h1;
      lock_cnt_ff <= 32'h0000_0000;
      locked_ff <= 1'b0;
    end else begin
      ratio_prev_ff <= ratio;
      if (ratio != ratio_prev_ff) begin
        lock_cnt_ff <= 32'h0000_0000;
        locked_ff <= 1'b0;
      end else if (!locked_ff) begin
        if (lock_cnt_ff == LOCK_CYCLES - 1) begin
          locked_ff <= 1'b1;
        end
        lock_cnt_ff <= lock_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Conversion pipeline; the output flop makes the tenth stage
  generate
    for (genvar i = 0; i < `ADCC_LATENCY - 1; i++) begin : g_pipe
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pipe_ff[i] <= 16'h0000;
        end else if (i == 0) begin
          pipe_ff[i] <= {conv_in, 2'h0};
        end else begin
          pipe_ff[i] <= pipe_ff[(i == 0) ? 0 : i - 1]; // Index legal at head
        end
      end
    end
  endgenerate

  // Pattern replaces samples until calibration is done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_ff <= `ADCC_CAL_PATTERN;
    end else if (!cal_done_ff) begin
      data_ff <= `ADCC_CAL_PATTERN;
    end else begin
      data_ff <= pipe_ff[`ADCC_LATENCY-2];
    end
  end

  assign link.dev_reset_low_o = 1'b0;
  assign link.dev_reset_low_oe = por_drive_ff;
  assign link.sdo_o = 1'b1;
  assign link.sdo_oe = sdo_oe_ff; // Pull-up stands in for idle drive
  assign link.data_out = data_ff;
  assign link.output_clock_pair = oclk_ff;
  assign link.cfg_rdata = rdata_ff;
  assign link.cfg_rvalid = rvalid_ff;
  assign cal_done = cal_done_ff;
  assign dll_locked = locked_ff;
  assign dll_slow = dll_ctrl_ff[`ADCC_DLL_SLOW_BIT];
endmodule : adcc_dev

// file: rtl/adcc_host.sv
/*
  Host end: drives the reset pin and divider strap, passes configuration
  accesses and captures output data on the output clock.
  Assumes the same sys_clk feeds the device as its sample clock.
*/
`include "adcc_consts.svh"
`timescale 1ns/1ps
module adcc_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  adcc_if.host link,
  input wire logic user_recal,
  input wire adcc_pkg::adcc_pin_e div_strap,
  input wire logic user_wr,
  input wire logic user_rd,
  input wire adcc_pkg::adcc_byte_t user_addr,
  input wire adcc_pkg::adcc_byte_t user_wdata,
  output adcc_pkg::adcc_byte_t user_rdata,
  output logic user_rvalid,
  output logic user_busy,
  output adcc_pkg::adcc_word_t cap_data,
  output logic cap_valid
);
  import adcc_pkg::*;

  logic [1:0] low_cnt_ff;
  logic drive_ff;
  logic busy_ff;
  logic seen_pat_ff;
  logic wr_ff;
  logic rd_ff;
  adcc_byte_t addr_ff;
  adcc_byte_t wdata_ff;
  adcc_byte_t rdata_ff;
  logic rvalid_ff;
  adcc_pin_e strap_ff;
  logic oclk_prev_ff;
  adcc_word_t cap_ff;
  logic cap_valid_ff;

  // Recalibration pulse held low for a fixed count of cycles
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_ff <= 1'b0;
      low_cnt_ff <= 2'h0;
    end else if (user_recal && !drive_ff) begin
      drive_ff <= 1'b1;
      low_cnt_ff <= 2'(`ADCC_RECAL_CYC - 1);
    end else if (drive_ff) begin
      if (low_cnt_ff == 2'h0) begin
        drive_ff <= 1'b0;
      end
      low_cnt_ff <= low_cnt_ff - 2'h1;
    end
  end

  // Busy from reset or recal until data leaves the calibration pattern;
  // words caught before the pattern shows are stale and must not clear it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || user_recal) begin
      busy_ff <= 1'b1;
      seen_pat_ff <= 1'b0;
    end else if (cap_valid_ff && cap_ff == `ADCC_CAL_PATTERN) begin
      seen_pat_ff <= 1'b1;
    end else if (cap_valid_ff && seen_pat_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // Configuration held off while calibrating; refused requests vanish
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      wr_ff <= user_wr && !busy_ff;
      rd_ff <= user_rd && !user_wr && !busy_ff;
      addr_ff <= user_addr;
      wdata_ff <= user_wdata;
      rvalid_ff <= link.cfg_rvalid;
      rdata_ff <= link.cfg_rdata;
    end
  end

  // Strap and capture; clock is never gated or switched here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strap_ff <= ADCC_PIN_FLOAT;
      oclk_prev_ff <= 1'b0;
      cap_ff <= 16'h0000;
      cap_valid_ff <= 1'b0;
    end else begin
      strap_ff <= div_strap;
      oclk_prev_ff <= link.output_clock_pair;
      cap_valid_ff <= link.output_clock_pair && !oclk_prev_ff;
      if (link.output_clock_pair && !oclk_prev_ff) begin
        cap_ff <= link.data_out;
      end
    end
  end

  // Serial data output is left to the device pull-up
  assign link.host_reset_low_o = 1'b0;
  assign link.host_reset_low_oe = drive_ff;
  assign link.divider_select_pin = strap_ff;
  assign link.cfg_wr = wr_ff;
  assign link.cfg_rd = rd_ff;
  assign link.cfg_addr = addr_ff;
  assign link.cfg_wdata = wdata_ff;
  assign user_rdata = rdata_ff;
  assign user_rvalid = rvalid_ff;
  assign user_busy = busy_ff;
  assign cap_data = cap_ff;
  assign cap_valid = cap_valid_ff;
endmodule : adcc_host

// file: verif/adcc_assertions.sv
/*
  Checker for the converter control link: timing relations between the
  reset pin, calibration status, output clock, data and config answers.
  Assumes it sits beside the link interface and shares its CAL_CYCLES.
*/
`timescale 1ns/1ps
module adcc_checker #(
  parameter int CAL_CYCLES = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dev_reset_low_o,
  input wire logic dev_reset_low_oe,
  input wire logic reset_low_pin,
  input wire logic cfg_rd,
  input wire adcc_pkg::adcc_byte_t cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire adcc_pkg::adcc_word_t data_out,
  input wire logic output_clock_pair
);
  import adcc_pkg::*;
  // Calibration window; pin sync and state entry add a few cycles on top
  localparam int CAL_LO = CAL_CYCLES - 12;
  localparam int CAL_HI = CAL_CYCLES + 4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Pin pulled low after power-on, then let go
  AST_POR_HOLD: assert property (
    $rose(rst_n) |-> (dev_reset_low_oe && !dev_reset_low_o) [*8] ##[1:30] !dev_reset_low_oe)
    else $error("reset pin not held then released after power-on");
  // Sync delay of the pin is allowed for before judging the outputs
  AST_CLK_LOW: assert property (
    !reset_low_pin [*5] |-> !output_clock_pair && data_out == 16'hcccc)
    else $error("output clock or data wrong while reset pin low");
  AST_CLK_START: assert property (
    $rose(reset_low_pin) |-> ##[1:12] $rose(output_clock_pair))
    else $error("output clock did not resume after reset pin release");
  AST_CAL_PATTERN: assert property (
    sdo_oe && $past(sdo_oe) |-> data_out == 16'hcccc)
    else $error("data not showing calibration pattern");
  AST_CAL_WINDOW: assert property (
    $rose(reset_low_pin) |-> ##4 sdo_oe [*8] ##[CAL_LO:CAL_HI] !sdo_oe)
    else $error("calibration length out of window");
  AST_RD_ANSWER: assert property (
    cfg_rd |=> cfg_rvalid)
    else $error("config read not answered next cycle");
  AST_RD_CAUSE: assert property (
    cfg_rvalid |-> $past(cfg_rd))
    else $error("config answer without a read");
  AST_RD_UPPER: assert property (
    cfg_rvalid |-> cfg_rdata[7:3] == 5'h00)
    else $error("config answer has bits set above the mapped fields");
  AST_SDO_PULL: assert property (
    sdo_oe |-> sdo_o)
    else $error("serial output not pulled high during calibration");
endmodule : adcc_checker

// file: verif/adc_calibration_clock_control_test.sv
/*
  Self-checking bench for the device and host ends joined by the link.
  Assumes a 125 MHz clock and shortened calibration and lock counts.
*/
`timescale 1ns/1ps
module adc_calibration_clock_control_test;
  import adcc_pkg::*;
  localparam int CAL = 64;
  localparam int LOCK = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic user_recal = 1'b0;
  adcc_pin_e div_strap = ADCC_PIN_GND;
  logic user_wr = 1'b0;
  logic user_rd = 1'b0;
  adcc_byte_t user_addr = 8'h00;
  adcc_byte_t user_wdata = 8'h00;
  logic [13:0] conv_in = 14'h0f0;
  adcc_byte_t user_rdata, rd_val;
  adcc_word_t cap_data;
  logic user_rvalid, user_busy, cap_valid, cal_done, dll_locked, dll_slow;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  // Clock at 8 ns period
  always #4 sys_clk = ~sys_clk;

  adcc_if adcc_if_i ();
  adcc_dev #(.CAL_CYCLES(CAL), .LOCK_CYCLES(LOCK)) adcc_dev_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .link(adcc_if_i), .conv_in(conv_in), .cal_done(cal_done),
    .dll_locked(dll_locked), .dll_slow(dll_slow));
  adcc_host adcc_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(adcc_if_i),
    .user_recal(user_recal), .div_strap(div_strap), .user_wr(user_wr), .user_rd(user_rd),
    .user_addr(user_addr), .user_wdata(user_wdata), .user_rdata(user_rdata),
    .user_rvalid(user_rvalid), .user_busy(user_busy), .cap_data(cap_data),
    .cap_valid(cap_valid));
  adcc_checker #(.CAL_CYCLES(CAL)) adcc_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .dev_reset_low_o(adcc_if_i.dev_reset_low_o),
    .dev_reset_low_oe(adcc_if_i.dev_reset_low_oe), .reset_low_pin(adcc_if_i.reset_low_pin),
    .cfg_rd(adcc_if_i.cfg_rd), .cfg_rdata(adcc_if_i.cfg_rdata),
    .cfg_rvalid(adcc_if_i.cfg_rvalid), .sdo_o(adcc_if_i.sdo_o), .sdo_oe(adcc_if_i.sdo_oe),
    .data_out(adcc_if_i.data_out), .output_clock_pair(adcc_if_i.output_clock_pair));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Advance n edges, landing just after the last so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // One config access via the host; extra ticks let the register land
  task automatic acc(input logic wr, input adcc_byte_t a, input adcc_byte_t d);
    int k;
    user_wr = wr;
    user_rd = !wr;
    user_addr = a;
    user_wdata = d;
    tick(1);
    user_wr = 1'b0;
    user_rd = 1'b0;
    for (k = 0; k < 8 && !wr && user_rvalid !== 1'b1; k++) tick(1);
    rd_val = user_rdata;
    if (!wr) chk("rvalid", user_rvalid, 1'b1);
    tick(2);
  endtask : acc

  // Cycles the output clock stays high after its next rising edge
  task automatic half(output int n);
    int k;
    n = 0;
    for (k = 0; k < 20 && adcc_if_i.output_clock_pair !== 1'b0; k++) tick(1);
    for (k = 0; k < 20 && adcc_if_i.output_clock_pair !== 1'b1; k++) tick(1);
    for (k = 0; k < 20 && adcc_if_i.output_clock_pair === 1'b1; k++) begin
      n++;
      tick(1);
    end
  endtask : half

  // Power-on: pin held, pattern out, reads refused, then calibrated
  task automatic t_por();
    int k;
    logic seen = 1'b0;
    tick(2);
    chk("dev_hold", adcc_if_i.dev_reset_low_oe, 1'b1);
    chk("clk_low", adcc_if_i.output_clock_pair, 1'b0);
    chk("pattern", adcc_if_i.data_out, 16'hcccc);
    chk("sdo_up", adcc_if_i.sdo_o, 1'b1);
    user_rd = 1'b1;
    user_addr = 8'hb6;
    tick(1);
    user_rd = 1'b0;
    for (k = 0; k < 5; k++) begin
      tick(1);
      if (user_rvalid !== 1'b0) seen = 1'b1;
    end
    chk("refused", seen, 1'b0);
    for (k = 0; k < 300 && user_busy !== 1'b0; k++) tick(1);
    chk("pin_up", adcc_if_i.reset_low_pin, 1'b1);
    acc(1'b0, 8'hb6, 8'h00);
    chk("cal_flag", rd_val[0], 1'b1);
    chk("cal_done", cal_done, 1'b1);
  endtask : t_por

  // A one-cycle code shows up exactly ten clocks later, left-justified
  task automatic t_lat();
    int k;
    conv_in = 14'h1a5;
    tick(1);
    conv_in = 14'h0f0;
    tick(8);
    chk("lat_pre", adcc_if_i.data_out, {14'h0f0, 2'b00});
    tick(1);
    chk("lat_hit", adcc_if_i.data_out, {14'h1a5, 2'b00});
    tick(1);
    chk("lat_post", adcc_if_i.data_out, {14'h0f0, 2'b00});
    // Host capture of the steady code on a later output clock rise
    tick(1);
    for (k = 0; k < 10 && cap_valid !== 1'b1; k++) tick(1);
    chk("cap_valid", cap_valid, 1'b1);
    chk("cap_data", cap_data, {14'h0f0, 2'b00});
  endtask : t_lat

  // Register masks, range select and an unmapped address
  task automatic t_regs();
    acc(1'b1, 8'h74, 8'hfd);
    acc(1'b0, 8'h74, 8'h00);
    chk("div_mask", rd_val, 8'h05);
    acc(1'b1, 8'h75, 8'hff);
    chk("slow_on", dll_slow, 1'b1);
    acc(1'b0, 8'h75, 8'h00);
    chk("slow_rd", rd_val, 8'h01);
    acc(1'b1, 8'h75, 8'h00);
    chk("slow_off", dll_slow, 1'b0);
    acc(1'b0, 8'h10, 8'h00);
    chk("unmapped", rd_val, 8'h00);
  endtask : t_regs

  // Every strap level, then overrides; each step changes the ratio so lock drops
  task automatic t_div();
    adcc_pin_e st [5] = '{ADCC_PIN_FLOAT, ADCC_PIN_GND, ADCC_PIN_SUPPLY, ADCC_PIN_SUPPLY,
                          ADCC_PIN_FLOAT};
    adcc_byte_t wv [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h06};
    int ex [5] = '{1, 2, 4, 1, 4};
    int n;
    int k;
    for (int i = 0; i < 5; i++) begin
      div_strap = st[i];
      acc(1'b1, 8'h74, wv[i]);
      for (k = 0; k < 8 && dll_locked !== 1'b0; k++) tick(1);
      chk("lock_drop", dll_locked, 1'b0);
      for (k = 0; k < LOCK + 8 && dll_locked !== 1'b1; k++) tick(1);
      chk("relock", dll_locked, 1'b1);
      half(n);
      chk("half_period", 16'(n), 16'(ex[i]));
    end
  endtask : t_div

  // Host pulse restarts calibration; length is timed and clock resume is checked
  task automatic t_recal();
    int k;
    int n = 0;
    logic up = 1'b0;
    user_recal = 1'b1;
    tick(1);
    user_recal = 1'b0;
    for (k = 0; k < 6 && adcc_if_i.reset_low_pin !== 1'b0; k++) tick(1);
    chk("pin_low", adcc_if_i.reset_low_pin, 1'b0);
    for (k = 0; k < 10 && adcc_if_i.reset_low_pin !== 1'b1; k++) tick(1);
    tick(3);
    chk("flag_clear", cal_done, 1'b0);
    chk("cal_pattern", adcc_if_i.data_out, 16'hcccc);
    chk("recal_busy", user_busy, 1'b1);
    for (n = 3; n < 200 && cal_done !== 1'b1; n++) begin
      tick(1);
      if (adcc_if_i.output_clock_pair === 1'b1) up = 1'b1;
    end
    chk("cal_len", (n >= CAL && n <= CAL + 8), 1'b1);
    chk("clk_resume", up, 1'b1);
    for (k = 0; k < 100 && user_busy !== 1'b0; k++) tick(1);
    acc(1'b0, 8'hb6, 8'h00);
    chk("recal_flag", rd_val[0], 1'b1);
  endtask : t_recal

  // Main sequence; reset held for ten clocks
  initial begin
    tick(10);
    rst_n = 1'b1;
    t_por();
    t_lat();
    t_regs();
    t_div();
    t_recal();
    end_sim();
  end

  // Hang guard well beyond the expected run of under a thousand clocks
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      end_sim();
    end
  end
endmodule : adc_calibration_clock_control_test
